// [hw/ebsd_regs.svh]
// Register offsets, field positions, reset values and counts of the
// external bus space decoder. Included by the package and the design.
`ifndef EBSD_REGS_SVH
`define EBSD_REGS_SVH

// Register byte addresses as seen on the Wishbone bus
`define EBSD_IDX_BUS_CONFIG_ONE      32'hffff8620
`define EBSD_IDX_BUS_CONFIG_TWO      32'hffff8622
`define EBSD_IDX_WAIT_CTRL_ONE       32'hffff8624
`define EBSD_IDX_WAIT_CTRL_TWO       32'hffff8626
`define EBSD_IDX_DRAM_AREA_CTRL      32'hffff862a
`define EBSD_IDX_REFRESH_CSR         32'hffff862c
`define EBSD_IDX_REFRESH_COUNTER     32'hffff862e
`define EBSD_IDX_REFRESH_COMPARE     32'hffff8630

// Power-on values
`define EBSD_RST_BUS_CONFIG_ONE      16'h200f
`define EBSD_RST_BUS_CONFIG_TWO      16'hffff
`define EBSD_RST_WAIT_CTRL_ONE       16'hffff
`define EBSD_RST_WAIT_CTRL_TWO       16'h000f
`define EBSD_RST_DRAM_AREA_CTRL      16'h0000
`define EBSD_RST_REFRESH_CSR         16'h0000
`define EBSD_RST_REFRESH_COUNTER     16'h0000
`define EBSD_RST_REFRESH_COMPARE     16'h0000

// First bus control register fields
`define EBSD_BC1_WRITE_MASK          16'h21ff
`define EBSD_BC1_TIMER_EN_BIT        13
`define EBSD_BC1_MUX_IO_BIT          8
`define EBSD_BC1_LONG_LSB            4
`define EBSD_BC1_WORD_LSB            0

// Refresh timer control/status fields
`define EBSD_RCSR_FLAG_BIT           7
`define EBSD_RCSR_IRQ_EN_BIT         6
`define EBSD_RCSR_CLK_MSB            5
`define EBSD_RCSR_CLK_LSB            3

// DRAM width field and wait fields
`define EBSD_DCR_WIDTH_MSB           1
`define EBSD_DCR_WIDTH_LSB           0
`define EBSD_WAIT_FIELD_BITS         4
`define EBSD_MUX_WIDTH_ADDR_BIT      14

`endif

// [hw/ebsd_pkg.sv]
// Types shared by the external bus space decoder.
// Assumes ebsd_regs.svh is on the include path.
`include "ebsd_regs.svh"
package ebsd_pkg;
  typedef enum logic [3:0] {
    SP_ROM  = 4'h0,
    SP_CS0  = 4'h1,
    SP_CS1  = 4'h2,
    SP_CS2  = 4'h3,
    SP_CS3  = 4'h4,
    SP_DRAM = 4'h5,
    SP_PERI = 4'h6,
    SP_RAM  = 4'h7,
    SP_RSVD = 4'h8
  } ebsd_space_type;

  typedef enum logic [1:0] {
    WD_8  = 2'h0,
    WD_16 = 2'h1,
    WD_32 = 2'h2
  } ebsd_width_type;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
  } ebsd_req_type;

  typedef struct packed {
    ebsd_space_type space;
    ebsd_width_type width;
    logic           fault;
  } ebsd_result_type;
endpackage : ebsd_pkg

// [hw/ebsd_pin_sync.sv]
// Three-stage input synchroniser for pins from outside the clock domain.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ebsd_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Pin side
  input  wire logic [WIDTH-1:0] pin,
  // Filtered level
  output var  logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_three;
  logic [WIDTH-1:0] next_level;

  // A bit moves only when the last two stages agree
  assign next_level = (stage_three & (stage_two ~^ stage_three))
                    | (level & (stage_two ^ stage_three));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage_one   <= INIT;
      stage_two   <= INIT;
      stage_three <= INIT;
      level       <= INIT;
    end
    else
    begin
      stage_one   <= pin;
      stage_two   <= stage_one;
      stage_three <= stage_two;
      level       <= next_level;
    end
  end
endmodule : ebsd_pin_sync
`default_nettype wire

// [hw/ebsd_decoder.sv]
// External bus space decoder: address split, chip selects, bus widths,
// control registers on classic Wishbone and the refresh interval timer.
// Assumes rst is the power-on reset; manual reset only aborts accesses.
`timescale 1ns/1ns
`default_nettype none
`include "ebsd_regs.svh"
module ebsd_decoder (
  // Clock, power-on reset and manual reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 manual_rst,
  // Wishbone register slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [31:0]          wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output var  logic [31:0]          wb_dat_o,
  output var  logic                 wb_ack_o,
  output var  logic                 wb_err_o,
  // Internal access request
  input  wire logic                 acc_valid,
  input  wire ebsd_pkg::ebsd_req_type acc_req,
  output var  logic                 acc_ready,
  output var  logic                 acc_done,
  output var  ebsd_pkg::ebsd_result_type acc_result,
  // Mode and wait pins
  input  wire logic                 rom_enable_pin,
  input  wire logic                 single_chip_pin,
  input  wire logic                 cs0_wide_pin,
  input  wire logic                 wait_n_pin,
  // External bus
  output var  logic [3:0]           chip_select_n,
  output var  logic [21:0]          ext_addr,
  output var  ebsd_pkg::ebsd_width_type ext_width,
  // Side controls
  output var  logic                 timer_regs_access_enable,
  output var  logic                 refresh_compare_irq
);
  import ebsd_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HOLD = 3'b100
  } ebsd_state_type;

  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    byte_addr = idx;
  endfunction : byte_addr

  function automatic ebsd_space_type decode_space(
    input logic [31:0] a,
    input logic        rom_en,
    input logic        single);
    ebsd_space_type s;
    s = SP_RSVD;
    if (a[31:24] == 8'h00)
    begin
      unique case (a[23:22])
        2'h0: s = (rom_en && a[21]) || !rom_en ? SP_CS0 : SP_RSVD;
        2'h1: s = SP_CS1;
        2'h2: s = SP_CS2;
        2'h3: s = SP_CS3;
      endcase
      if (rom_en && a[23:18] == 6'h00)
        s = SP_ROM;
    end
    else if (a[31:24] == 8'h01)
      s = SP_DRAM;
    else if (a[31:11] == 21'h1ffff0)
      s = SP_PERI;
    else if (a[31:12] == 20'hfffff)
      s = SP_RAM;
    if (single && s != SP_ROM && s != SP_PERI && s != SP_RAM)
      s = SP_RSVD;
    decode_space = s;
  endfunction : decode_space

  function automatic ebsd_width_type size_of(input logic long_bit,
                                             input logic word_bit);
    size_of = long_bit ? WD_32 : (word_bit ? WD_16 : WD_8);
  endfunction : size_of

  // Registers
  logic [15:0] bus_config_one;
  logic [15:0] bus_config_two;
  logic [15:0] wait_state_ctrl_one;
  logic [15:0] wait_state_ctrl_two;
  logic [15:0] dram_area_ctrl;
  logic [15:0] refresh_timer_ctrl_status;
  logic [15:0] refresh_counter;
  logic [15:0] refresh_compare_constant;

  // Synchronised pins
  logic [3:0] pin_level;
  logic       rom_en;
  logic       single;
  logic       cs0_wide;
  logic       wait_req;

  ebsd_pin_sync #(
    .WIDTH (4),
    .INIT  (4'h8)
  ) u_pin_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   ({wait_n_pin, cs0_wide_pin, single_chip_pin, rom_enable_pin}),
    .level (pin_level)
  );

  assign rom_en   = pin_level[0];
  assign single   = pin_level[1];
  assign cs0_wide = pin_level[2];
  assign wait_req = !pin_level[3];

  // Bus decode
  wire        wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire        sel_bc1 = wb_adr_i == byte_addr(`EBSD_IDX_BUS_CONFIG_ONE);
  wire        sel_bc2 = wb_adr_i == byte_addr(`EBSD_IDX_BUS_CONFIG_TWO);
  wire        sel_wc1 = wb_adr_i == byte_addr(`EBSD_IDX_WAIT_CTRL_ONE);
  wire        sel_wc2 = wb_adr_i == byte_addr(`EBSD_IDX_WAIT_CTRL_TWO);
  wire        sel_dcr = wb_adr_i == byte_addr(`EBSD_IDX_DRAM_AREA_CTRL);
  wire        sel_csr = wb_adr_i == byte_addr(`EBSD_IDX_REFRESH_CSR);
  wire        sel_cnt = wb_adr_i == byte_addr(`EBSD_IDX_REFRESH_COUNTER);
  wire        sel_cor = wb_adr_i == byte_addr(`EBSD_IDX_REFRESH_COMPARE);
  wire        mapped = sel_bc1 | sel_bc2 | sel_wc1 | sel_wc2
                     | sel_dcr | sel_csr | sel_cnt | sel_cor;
  wire        wr = wb_req && wb_we_i && mapped;
  wire [15:0] lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] rd_data =
      ({16{sel_bc1}} & (bus_config_one & `EBSD_BC1_WRITE_MASK))
    | ({16{sel_bc2}} & bus_config_two)
    | ({16{sel_wc1}} & wait_state_ctrl_one)
    | ({16{sel_wc2}} & wait_state_ctrl_two)
    | ({16{sel_dcr}} & dram_area_ctrl)
    | ({16{sel_csr}} & refresh_timer_ctrl_status)
    | ({16{sel_cnt}} & refresh_counter)
    | ({16{sel_cor}} & refresh_compare_constant);

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] m);
    merge = (old & ~m) | (wb_dat_i[15:0] & m);
  endfunction : merge

  // Refresh interval timer
  logic [7:0] prescale;
  wire  [2:0] clk_sel = refresh_timer_ctrl_status[`EBSD_RCSR_CLK_MSB:`EBSD_RCSR_CLK_LSB];
  wire  [7:0] tick_mask = 8'hff >> (3'h7 - clk_sel);
  wire        tick = clk_sel != 3'h0 && (prescale & tick_mask) == 8'h00;
  wire        match = tick && refresh_counter == refresh_compare_constant;
  wire        csr_flag = refresh_timer_ctrl_status[`EBSD_RCSR_FLAG_BIT];
  wire        flag_clear = wr && sel_csr && wb_sel_i[0]
                        && !wb_dat_i[`EBSD_RCSR_FLAG_BIT];
  wire [15:0] csr_merged = merge(refresh_timer_ctrl_status, lane);

  // Register file: reset by power-on only, manual reset leaves it alone
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus_config_one            <= `EBSD_RST_BUS_CONFIG_ONE;
      bus_config_two            <= `EBSD_RST_BUS_CONFIG_TWO;
      wait_state_ctrl_one       <= `EBSD_RST_WAIT_CTRL_ONE;
      wait_state_ctrl_two       <= `EBSD_RST_WAIT_CTRL_TWO;
      dram_area_ctrl            <= `EBSD_RST_DRAM_AREA_CTRL;
      refresh_timer_ctrl_status <= `EBSD_RST_REFRESH_CSR;
      refresh_counter           <= `EBSD_RST_REFRESH_COUNTER;
      refresh_compare_constant  <= `EBSD_RST_REFRESH_COMPARE;
      prescale                  <= 8'h00;
    end
    else
    begin
      prescale <= prescale + 8'h01;
      if (wr && sel_bc1)
        bus_config_one <= merge(bus_config_one, lane & `EBSD_BC1_WRITE_MASK);
      if (wr && sel_bc2)
        bus_config_two <= merge(bus_config_two, lane);
      if (wr && sel_wc1)
        wait_state_ctrl_one <= merge(wait_state_ctrl_one, lane);
      if (wr && sel_wc2)
        wait_state_ctrl_two <= merge(wait_state_ctrl_two, lane);
      if (wr && sel_dcr)
        dram_area_ctrl <= merge(dram_area_ctrl, lane);
      if (wr && sel_cor)
        refresh_compare_constant <= merge(refresh_compare_constant, lane);
      // Bus write to the counter wins over the timer
      if (wr && sel_cnt)
        refresh_counter <= merge(refresh_counter, lane);
      else if (match)
        refresh_counter <= 16'h0000;
      else if (tick)
        refresh_counter <= refresh_counter + 16'h0001;
      if (wr && sel_csr)
        refresh_timer_ctrl_status[6:0] <= csr_merged[6:0];
      // Flag: a match in the clearing cycle still sets it
      if (match)
        refresh_timer_ctrl_status[`EBSD_RCSR_FLAG_BIT] <= 1'b1;
      else if (flag_clear)
        refresh_timer_ctrl_status[`EBSD_RCSR_FLAG_BIT] <= 1'b0;
    end
  end

  assign timer_regs_access_enable = bus_config_one[`EBSD_BC1_TIMER_EN_BIT];
  assign refresh_compare_irq =
    csr_flag && refresh_timer_ctrl_status[`EBSD_RCSR_IRQ_EN_BIT];

  // Wishbone answer one cycle after the request; unmapped gets err
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req && mapped;
      wb_err_o <= wb_req && !mapped;
      wb_dat_o <= (wb_req && !wb_we_i) ? {16'h0000, rd_data} : 32'h0000_0000;
    end
  end

  // Access decode
  wire ebsd_space_type space = decode_space(acc_req.addr, rom_en, single);
  wire       mux_io = bus_config_one[`EBSD_BC1_MUX_IO_BIT];
  wire [3:0] long_bits = bus_config_one[`EBSD_BC1_LONG_LSB +: 4];
  wire [3:0] word_bits = bus_config_one[`EBSD_BC1_WORD_LSB +: 4];
  wire [1:0] cs_idx = acc_req.addr[23:22];
  wire [1:0] dram_code = dram_area_ctrl[`EBSD_DCR_WIDTH_MSB:`EBSD_DCR_WIDTH_LSB];
  wire       is_cs = space inside {SP_CS0, SP_CS1, SP_CS2, SP_CS3};
  wire       is_ext = is_cs || space == SP_DRAM;
  ebsd_width_type width;

  always_comb
  begin
    width = WD_32;
    if (space == SP_PERI)
      width = WD_16;
    else if (space == SP_DRAM)
      width = dram_code[1] ? WD_32 : (dram_code[0] ? WD_16 : WD_8);
    else if (space == SP_CS3 && mux_io)
      width = acc_req.addr[`EBSD_MUX_WIDTH_ADDR_BIT] ? WD_16 : WD_8;
    else if (space == SP_CS0 && !rom_en)
      width = cs0_wide ? WD_32 : WD_16;
    else if (is_cs)
      width = size_of(long_bits[cs_idx], word_bits[cs_idx]);
  end

  // Wait states: one nibble per chip-select space, DRAM from second word
  wire [3:0] cs_wait = wait_state_ctrl_one[cs_idx*`EBSD_WAIT_FIELD_BITS +: 4];
  wire [3:0] load_wait = space == SP_DRAM ? wait_state_ctrl_two[3:0] : cs_wait;

  ebsd_state_type state;
  ebsd_state_type next_state;
  logic [3:0]     wait_left;
  wire            take = acc_valid && acc_ready;
  wire            ext_end = state == ST_HOLD && !wait_req;

  assign acc_ready = state == ST_IDLE;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (take && is_ext)
          next_state = ST_WAIT;
      ST_WAIT:
        if (wait_left == 4'h0)
          next_state = ST_HOLD;
      ST_HOLD:
        if (!wait_req)
          next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst || manual_rst)
    begin
      state         <= ST_IDLE;
      wait_left     <= 4'h0;
      chip_select_n <= 4'hf;
      ext_addr      <= 22'h000000;
      ext_width     <= WD_32;
      acc_done      <= 1'b0;
      acc_result    <= '{space: SP_RSVD, width: WD_32, fault: 1'b0};
    end
    else
    begin
      state    <= next_state;
      acc_done <= (take && !is_ext) || ext_end;
      if (take)
      begin
        acc_result <= '{space: space, width: width, fault: space == SP_RSVD};
        wait_left  <= load_wait;
        if (is_ext)
        begin
          ext_addr  <= acc_req.addr[21:0];
          ext_width <= width;
          if (is_cs)
            chip_select_n <= ~(4'h1 << cs_idx);
        end
      end
      else if (state == ST_WAIT && wait_left != 4'h0)
        wait_left <= wait_left - 4'h1;
      if (ext_end)
        chip_select_n <= 4'hf;
    end
  end

  // Assertions
  a_ram_one_state: assert property (@(posedge clk) disable iff (rst || manual_rst)
    take && space == SP_RAM |=> acc_done && acc_result.width == WD_32)
    else $error("RAM access not finished in one state");

  a_rom_one_state: assert property (@(posedge clk) disable iff (rst || manual_rst)
    take && space == SP_ROM |=> acc_done && acc_result.space == SP_ROM)
    else $error("ROM access not finished in one state");

  a_cs_one_hot: assert property (@(posedge clk) disable iff (rst || manual_rst)
    take && is_cs |=> chip_select_n == ~(4'h1 << $past(cs_idx)))
    else $error("Chip select does not match address bits 23..22");

  a_ext_addr_low: assert property (@(posedge clk) disable iff (rst || manual_rst)
    take && is_ext |=> ext_addr == $past(acc_req.addr[21:0]))
    else $error("External address differs from low address bits");

  a_single_chip: assert property (@(posedge clk) disable iff (rst || manual_rst)
    take && single && acc_req.addr[31:25] == 7'h00
      && !(rom_en && acc_req.addr[23:18] == 6'h00) |=> acc_result.fault && chip_select_n == 4'hf)
    else $error("External space decoded in single-chip mode");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(sel_bc1 && !wb_we_i) |-> wb_dat_o[15:14] == 2'h0 && wb_dat_o[12:9] == 4'h0)
    else $error("Reserved config bits read as one");

  a_mux_width: assert property (@(posedge clk) disable iff (rst || manual_rst)
    take && space == SP_CS3 && mux_io |=>
      ext_width == ($past(acc_req.addr[14]) ? WD_16 : WD_8))
    else $error("Multiplexed space width ignores address bit 14");

  a_wait_count: assert property (@(posedge clk) disable iff (rst || manual_rst)
    take && is_ext && load_wait == 4'h2 |=> state == ST_WAIT [*3] ##1 state == ST_HOLD)
    else $error("Programmed wait states not inserted");

  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    match |=> csr_flag && refresh_counter == 16'h0000)
    else $error("Compare match did not set flag and clear counter");

  a_timer_gate: assert property (@(posedge clk)
    $fell(rst) |-> timer_regs_access_enable && bus_config_one == `EBSD_RST_BUS_CONFIG_ONE)
    else $error("Timer access enable not set after power-on");
endmodule : ebsd_decoder
`default_nettype wire

// [testbench/ebsd_ext_dev.sv]
// Model of an external device that stretches cycles through its wait line.
// Assumes active-low chip selects; the wait line idles high by its pull-up.
`timescale 1ns/1ns
`default_nettype none
module ebsd_ext_dev (
  // Clock
  input  wire logic       clk,
  // Bus side
  input  wire logic [3:0] chip_select_n,
  input  wire logic [3:0] hold_cycles,
  output var  logic       wait_n_pin
);
  logic [3:0] left;
  logic       was_idle;
  initial
  begin
    left = 4'h0;
    was_idle = 1'b1;
  end
  always @(posedge clk)
  begin
    if (was_idle && chip_select_n != 4'hf)
      left <= hold_cycles;
    else if (left != 4'h0)
      left <= left - 4'h1;
    was_idle <= (chip_select_n == 4'hf);
  end
  // Released line is pulled up, so it reads inactive
  always_comb wait_n_pin = (left == 4'h0);
endmodule : ebsd_ext_dev
`default_nettype wire

// [testbench/ebsd_decoder_bench.sv]
// Testbench of the external bus space decoder: registers, decode, waits, timer.
// Assumes ebsd_pkg is compiled and ebsd_regs.svh is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "ebsd_regs.svh"
module ebsd_decoder_bench;
  import ebsd_pkg::*;
  logic clk, rst, manual_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i, chip_select_n, hold_cycles;
  logic        acc_valid, acc_ready, acc_done, rom_enable_pin, single_chip_pin;
  logic        cs0_wide_pin, wait_n_pin, timer_regs_access_enable, refresh_compare_irq;
  logic [21:0] ext_addr;
  ebsd_req_type    acc_req;
  ebsd_result_type acc_result;
  ebsd_width_type  ext_width;
  int err_total, check_count, last_n;
  logic [31:0] offs [8] = '{`EBSD_IDX_BUS_CONFIG_ONE, `EBSD_IDX_BUS_CONFIG_TWO,
    `EBSD_IDX_WAIT_CTRL_ONE, `EBSD_IDX_WAIT_CTRL_TWO, `EBSD_IDX_DRAM_AREA_CTRL,
    `EBSD_IDX_REFRESH_CSR, `EBSD_IDX_REFRESH_COUNTER, `EBSD_IDX_REFRESH_COMPARE};
  logic [15:0] rsts [8] = '{16'h200f, 16'hffff, 16'hffff, 16'h000f, 16'h0, 16'h0,
    16'h0, 16'h0};

  ebsd_decoder u_ebsd_decoder (.clk(clk), .rst(rst), .manual_rst(manual_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .acc_valid(acc_valid), .acc_req(acc_req),
    .acc_ready(acc_ready), .acc_done(acc_done), .acc_result(acc_result),
    .rom_enable_pin(rom_enable_pin), .single_chip_pin(single_chip_pin),
    .cs0_wide_pin(cs0_wide_pin), .wait_n_pin(wait_n_pin),
    .chip_select_n(chip_select_n), .ext_addr(ext_addr), .ext_width(ext_width),
    .timer_regs_access_enable(timer_regs_access_enable),
    .refresh_compare_irq(refresh_compare_irq));
  ebsd_ext_dev u_ebsd_ext_dev (.clk(clk), .chip_select_n(chip_select_n),
    .hold_cycles(hold_cycles), .wait_n_pin(wait_n_pin));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
  begin
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask : check

  function automatic logic [31:0] ra(input logic [31:0] off);
    return off;
  endfunction : ra

  // Holds the request until ack or err is seen at a rising edge
  task automatic wb(input logic we, input logic [31:0] adr, input logic [15:0] wd,
                    output logic [15:0] rd, output logic er);
    int n;
  begin
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0, wd};
    do
    begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    rd = wb_dat_o[15:0];
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  endtask : wb

  // Space 4'hf skips the space compare; lat 0 skips the latency compare
  task automatic acc(input logic [31:0] a, input logic [3:0] sp, input logic [1:0] wd,
                     input logic flt, input logic [3:0] cs, input int lat);
    logic [3:0]  scs;
    logic [21:0] sa;
    logic [1:0]  sw;
  begin
    last_n = 0;
    scs = 4'hf;
    sa = '0;
    sw = '0;
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_req <= '{addr: a, write: 1'b0};
    @(posedge clk);
    acc_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      last_n++;
      if (chip_select_n !== 4'hf)
      begin
        scs = chip_select_n;
        sa = ext_addr;
        sw = ext_width;
      end
    end while (acc_done !== 1'b1 && last_n < 100);
    if (last_n >= 100)
    begin
      err_total++;
      tally_and_finish();
    end
    if (sp != 4'hf) check({28'h0, acc_result.space}, {28'h0, sp});
    check({31'h0, acc_result.fault}, {31'h0, flt});
    if (!flt) check({30'h0, acc_result.width}, {30'h0, wd});
    check({28'h0, scs}, {28'h0, cs});
    if (cs != 4'hf) check({10'h0, sa}, {10'h0, a[21:0]});
    if (cs != 4'hf) check({30'h0, sw}, {30'h0, wd});
    if (lat != 0) check(last_n, lat);
  end
  endtask : acc

  task automatic t_regs;
    logic [15:0] rd;
    logic        er;
  begin
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b0, ra(offs[i]), 16'h0, rd, er);
      check({16'h0, rd}, {16'h0, rsts[i]});
    end
    check({31'h0, timer_regs_access_enable}, 1);
    wb(1'b1, ra(`EBSD_IDX_WAIT_CTRL_ONE), 16'h0, rd, er);
    wb(1'b1, ra(`EBSD_IDX_WAIT_CTRL_TWO), 16'h0, rd, er);
  end
  endtask : t_regs

  task automatic t_bc1;
    logic [15:0] rd;
    logic        er;
  begin
    wb(1'b1, ra(`EBSD_IDX_BUS_CONFIG_ONE), 16'hffff, rd, er);
    wb(1'b0, ra(`EBSD_IDX_BUS_CONFIG_ONE), 16'h0, rd, er);
    check({16'h0, rd}, 32'h21ff);
    wb(1'b1, ra(`EBSD_IDX_BUS_CONFIG_ONE), 16'h000f, rd, er);
    check({31'h0, timer_regs_access_enable}, 0);
    @(posedge clk);
    manual_rst <= 1'b1;
    repeat (2) @(posedge clk);
    manual_rst <= 1'b0;
    wb(1'b0, ra(`EBSD_IDX_BUS_CONFIG_ONE), 16'h0, rd, er);
    check({16'h0, rd}, 32'h000f);
    wb(1'b1, ra(32'hffff8628), 16'h1234, rd, er);
    check({31'h0, er}, 1);
    wb(1'b1, ra(`EBSD_IDX_BUS_CONFIG_ONE), 16'h200f, rd, er);
  end
  endtask : t_bc1

  task automatic t_decode;
  begin
    acc(32'h00000000, SP_ROM, WD_32, 1'b0, 4'hf, 1);
    acc(32'h00040000, 4'hf, WD_8, 1'b1, 4'hf, 0);
    acc(32'h00200000, SP_CS0, WD_16, 1'b0, 4'he, 3);
    acc(32'h00400000, SP_CS1, WD_16, 1'b0, 4'hd, 3);
    acc(32'h00abcdef, SP_CS2, WD_16, 1'b0, 4'hb, 3);
    acc(32'h00c00000, SP_CS3, WD_16, 1'b0, 4'h7, 3);
    acc(32'h01000000, SP_DRAM, WD_8, 1'b0, 4'hf, 0);
    acc(32'h02000000, 4'hf, WD_8, 1'b1, 4'hf, 0);
    acc(32'hffff8000, SP_PERI, WD_16, 1'b0, 4'hf, 0);
    acc(32'hfffff000, SP_RAM, WD_32, 1'b0, 4'hf, 1);
  end
  endtask : t_decode

  task automatic t_sizes;
    logic [15:0] rd;
    logic        er;
  begin
    wb(1'b1, ra(`EBSD_IDX_BUS_CONFIG_ONE), 16'h2120, rd, er);
    acc(32'h00400000, SP_CS1, WD_32, 1'b0, 4'hd, 3);
    acc(32'h00800000, SP_CS2, WD_8, 1'b0, 4'hb, 3);
    acc(32'h00200000, SP_CS0, WD_8, 1'b0, 4'he, 3);
    acc(32'h00c00000, SP_CS3, WD_8, 1'b0, 4'h7, 0);
    acc(32'h00c04000, SP_CS3, WD_16, 1'b0, 4'h7, 0);
    wb(1'b1, ra(`EBSD_IDX_BUS_CONFIG_ONE), 16'h200f, rd, er);
  end
  endtask : t_sizes

  task automatic t_modes;
  begin
    rom_enable_pin <= 1'b0;
    cs0_wide_pin <= 1'b1;
    repeat (6) @(posedge clk);
    acc(32'h00000000, SP_CS0, WD_32, 1'b0, 4'he, 3);
    cs0_wide_pin <= 1'b0;
    repeat (6) @(posedge clk);
    acc(32'h00100000, SP_CS0, WD_16, 1'b0, 4'he, 3);
    rom_enable_pin <= 1'b1;
    single_chip_pin <= 1'b1;
    repeat (6) @(posedge clk);
    acc(32'h00400000, 4'hf, WD_8, 1'b1, 4'hf, 0);
    acc(32'h01000000, 4'hf, WD_8, 1'b1, 4'hf, 0);
    acc(32'h00000000, SP_ROM, WD_32, 1'b0, 4'hf, 1);
    single_chip_pin <= 1'b0;
    repeat (6) @(posedge clk);
  end
  endtask : t_modes

  task automatic t_wait_timer;
    logic [15:0] rd;
    logic        er;
    int          n;
  begin
    wb(1'b1, ra(`EBSD_IDX_WAIT_CTRL_ONE), 16'h0420, rd, er);
    acc(32'h00400000, SP_CS1, WD_16, 1'b0, 4'hd, 5);
    // Four programmed waits let the filtered wait line arrive before the hold state
    hold_cycles <= 4'h6;
    acc(32'h00800000, SP_CS2, WD_16, 1'b0, 4'hb, 13);
    check({31'h0, last_n > 7}, 1);
    hold_cycles <= 4'h0;
    wb(1'b1, ra(`EBSD_IDX_REFRESH_COMPARE), 16'h0001, rd, er);
    wb(1'b1, ra(`EBSD_IDX_REFRESH_CSR), 16'h0048, rd, er);
    n = 0;
    while (refresh_compare_irq !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    check({31'h0, refresh_compare_irq}, 1);
    // Stop the timer first so no match can coincide with the clearing write
    wb(1'b1, ra(`EBSD_IDX_REFRESH_CSR), 16'h00c0, rd, er);
    wb(1'b1, ra(`EBSD_IDX_REFRESH_CSR), 16'h0040, rd, er);
    @(posedge clk);
    check({31'h0, refresh_compare_irq}, 0);
  end
  endtask : t_wait_timer

  initial
  begin
    rst = 1'b1;
    manual_rst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'h3;
    acc_valid = 1'b0;
    acc_req = '0;
    rom_enable_pin = 1'b1;
    single_chip_pin = 1'b0;
    cs0_wide_pin = 1'b0;
    hold_cycles = 4'h0;
    err_total = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_bc1();
    t_decode();
    t_sizes();
    t_modes();
    t_wait_timer();
    tally_and_finish();
  end
endmodule : ebsd_decoder_bench
`default_nettype wire
